// *** logic/timer01_mode_clock_select.sv ***
// Purpose: Timer 0/1 counters, mode and clock-select registers
// Assumes: Register port and all pins synchronous to sys_clk
// Notes: Also hands Timer 2/3 clock enables to those timers
// Notes on behaviour
// - Timer 1 runs on run bit, gated by input 1 when gate enabled; while Timer 0 is split, run by mode alone
// - Timer 0 runs on run bit, gated by input 0 when gate enabled
// - Timer 1 counts selected clock, or falling edges of its pin unless Timer 0 is split
// - Timer 0 counts selected clock, or falling edges of its pin
// - Timer 1 modes: 13-bit, 16-bit, 8-bit reload, inactive
// - Timer 0 modes: 13-bit, 16-bit, 8-bit reload, split 8-bit pair
// - Timer 1 uses prescaler or system clock; ignored when counting pins
// - Timer 0 uses prescaler or system clock; ignored when counting pins
// - Prescaler: sysclk/12, /4, /48, or external clock /8
// - External /8 tick synchronised; external clock not above sysclk
// - Timer 2 high byte clock select, only in split mode
// - Timer 2 low byte clock: external selection or system clock
// - Timer 3 high byte clock select, only in split mode
// - Timer 3 low byte clock: external selection or system clock
// - Timer 0 low byte readable, writable, resets to zero
// - Timer 0 high byte readable, writable, resets to zero
// - Timer 1 low byte readable, writable, resets to zero
// - 13-bit mode: high byte plus low five bits; overflow sets flag
// - 8-bit reload: overflow sets flag, reloads low from high byte
// - Split mode high byte: timer clock, Timer 1 run bit, Timer 1 flag
// - Run bit never clears or reloads the count
`timescale 1ns/10ps
module timer01_mode_clock_select (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    input wire logic timer0_run_bit,
    input wire logic timer1_run_bit,
    input wire logic ext_gate_input0,
    input wire logic ext_gate_input1,
    input wire logic ext_ext_gate_input0_polarity,
    input wire logic ext_ext_gate_input1_polarity,
    input wire logic timer0_count_pin,
    input wire logic timer1_count_pin,
    input wire logic ext_clk_in,
    input wire logic timer0_flag_clear,
    input wire logic timer1_flag_clear,
    output logic timer0_overflow_flag,
    output logic timer1_overflow_flag,
    output logic timer1_overflow_pulse,
    input wire logic timer2_ext_clock_select,
    input wire logic timer2_split,
    input wire logic timer3_ext_clock_select,
    input wire logic timer3_split,
    output logic timer2_low_tick,
    output logic timer2_high_tick,
    output logic timer3_low_tick,
    output logic timer3_high_tick
);
    import timer01_pkg::*;

    typedef struct packed {
        logic [7:0] mode_cfg;
        logic [7:0] clk_sel;
        logic [7:0] c0_low;
        logic [7:0] c0_high;
        logic [7:0] c1_low;
        logic [7:0] c1_high;
        logic of0;
        logic of1;
        logic c1_pulse;
        logic [7:0] rdata;
    } core_state_t;

    typedef struct packed {
        logic [7:0] low;
        logic [7:0] high;
        logic ovf;
    } step_t;

    core_state_t q, d;

    logic tick12, tick4, tick48, tick_ext;
    logic [1:0] pin_fall;
    logic pre_tick;

    // Shared dividers and external clock tick
    timer_prescaler #(
        .DIV_A(SYS_DIV_12),
        .DIV_B(SYS_DIV_4),
        .DIV_C(SYS_DIV_48),
        .DIV_X(EXT_DIV_8)
    ) u_prescaler (
        .sys_clk(sys_clk),
        .srst(srst),
        .ext_clk_in(ext_clk_in),
        .tick_div_a(tick12),
        .tick_div_b(tick4),
        .tick_div_c(tick48),
        .tick_ext(tick_ext)
    );

    // Bit 0 is Timer 0 pin, bit 1 is Timer 1 pin
    pin_fall_detect #(
        .WIDTH(2)
    ) u_pin_fall (
        .sys_clk(sys_clk),
        .srst(srst),
        .pin_in({timer1_count_pin, timer0_count_pin}),
        .fall(pin_fall)
    );

    // Prescaled tick per shared select field
    always_comb begin
        case (prescale_sel_t'(q.clk_sel[PRESCALE_LSB +: 2]))
            PRESCALE_DIV12: pre_tick = tick12;
            PRESCALE_DIV4: pre_tick = tick4;
            PRESCALE_DIV48: pre_tick = tick48;
            PRESCALE_EXT_DIV8: pre_tick = tick_ext;
            default: pre_tick = tick12;
        endcase
    end

    // Timer clock: pin edges in counter function, else sysclk or prescaler
    function automatic logic pick_tick(input logic ct, input logic sys_sel,
        input logic fall, input logic pre);
        if (ct) begin
            pick_tick = fall;
        end else if (sys_sel) begin
            pick_tick = 1'b1;
        end else begin
            pick_tick = pre;
        end
    endfunction

    // Run gating: gate input must match its polarity when gating is on
    function automatic logic gated_run(input logic run, input logic gate_en,
        input logic gate_in, input logic pol);
        gated_run = run && (!gate_en || (gate_in == pol));
    endfunction

    // Timer 2/3 byte clock: system clock, or external choice
    function automatic logic t23_tick(input logic sys_sel, input logic xclk,
        input logic div12, input logic ext8);
        if (sys_sel) begin
            t23_tick = 1'b1;
        end else begin
            t23_tick = xclk ? ext8 : div12;
        end
    endfunction

    // One increment of a timer in modes 0 to 2
    function automatic step_t count_step(input timer_mode_t m,
        input logic [7:0] lo, input logic [7:0] hi);
        step_t s;
        logic [13:0] s13;
        logic [16:0] s16;
        logic [8:0] s8;
        s = '{low: lo, high: hi, ovf: 1'b0};
        s13 = {1'b0, hi, lo[LOW5_MSB:0]} + 14'h0001;
        s16 = {1'b0, hi, lo} + 17'h00001;
        s8 = {1'b0, lo} + 9'h001;
        case (m)
            MODE_13BIT: begin
                // Upper three low-byte bits left as they were
                s.low = {lo[7:LOW5_MSB+1], s13[LOW5_MSB:0]};
                s.high = s13[12:LOW5_MSB+1];
                s.ovf = s13[13];
            end
            MODE_16BIT: begin
                s.low = s16[7:0];
                s.high = s16[15:8];
                s.ovf = s16[16];
            end
            MODE_8BIT_RELOAD: begin
                s.low = s8[8] ? hi : s8[7:0];
                s.ovf = s8[8];
            end
            default: begin
                s.ovf = 1'b0;
            end
        endcase
        count_step = s;
    endfunction

    logic c0_go, c1_go, hi0_go;
    timer_mode_t c0_mode, c1_mode;
    logic c0_split;
    step_t c0_step, c1_step;
    logic [8:0] lo0_split_sum, hi0_split_sum;
    logic set_of0, set_of1;

    // Counting, register writes, flags and read data
    always_comb begin
        d = q;
        c0_mode = timer_mode_t'(q.mode_cfg[T0MODE_LSB +: 2]);
        c1_mode = timer_mode_t'(q.mode_cfg[T1MODE_LSB +: 2]);
        c0_split = (c0_mode == MODE_SPLIT);
        set_of0 = 1'b0;
        set_of1 = 1'b0;
        d.c1_pulse = 1'b0;

        // Timer 0 (low byte alone in split mode)
        c0_go = gated_run(timer0_run_bit, q.mode_cfg[GATEN0_BIT],
            ext_gate_input0, ext_ext_gate_input0_polarity) &&
            pick_tick(q.mode_cfg[CT0_BIT], q.clk_sel[C0_SYSCLK_BIT],
            pin_fall[0], pre_tick);
        c0_step = count_step(c0_mode, q.c0_low, q.c0_high);
        lo0_split_sum = {1'b0, q.c0_low} + 9'h001;
        if (c0_go) begin
            if (c0_split) begin
                d.c0_low = lo0_split_sum[7:0];
                set_of0 = lo0_split_sum[8];
            end else begin
                d.c0_low = c0_step.low;
                d.c0_high = c0_step.high;
                set_of0 = c0_step.ovf;
            end
        end

        // Split mode high byte: timer clock only, Timer 1 run bit
        hi0_go = c0_split && timer1_run_bit &&
            pick_tick(1'b0, q.clk_sel[C0_SYSCLK_BIT], 1'b0,
            pre_tick);
        hi0_split_sum = {1'b0, q.c0_high} + 9'h001;
        if (hi0_go) begin
            d.c0_high = hi0_split_sum[7:0];
            set_of1 = hi0_split_sum[8];
        end

        // Timer 1; while Timer 0 is split, run is set by mode alone
        if (c0_split) begin
            c1_go = (c1_mode != MODE_SPLIT) &&
                pick_tick(1'b0, q.clk_sel[C1_SYSCLK_BIT], 1'b0,
                pre_tick);
        end else begin
            c1_go = gated_run(timer1_run_bit, q.mode_cfg[GATEN1_BIT],
                ext_gate_input1, ext_ext_gate_input1_polarity) &&
                pick_tick(q.mode_cfg[CT1_BIT], q.clk_sel[C1_SYSCLK_BIT],
                pin_fall[1], pre_tick);
        end
        c1_step = count_step(c1_mode, q.c1_low, q.c1_high);
        if (c1_go && c1_mode != MODE_SPLIT) begin
            d.c1_low = c1_step.low;
            d.c1_high = c1_step.high;
            d.c1_pulse = c1_step.ovf;
            if (!c0_split) begin
                set_of1 = c1_step.ovf;
            end
        end

        // Software writes win over a count in the same cycle
        if (sfr_wr) begin
            case (sfr_addr)
                ADDR_MODE_CONFIG: d.mode_cfg = sfr_wdata;
                ADDR_CLOCK_SELECT: d.clk_sel = sfr_wdata;
                ADDR_C0_LOW: d.c0_low = sfr_wdata;
                ADDR_C0_HIGH: d.c0_high = sfr_wdata;
                ADDR_C1_LOW: d.c1_low = sfr_wdata;
                ADDR_C1_HIGH: d.c1_high = sfr_wdata;
                default: d.mode_cfg = q.mode_cfg;
            endcase
        end

        // Set beats clear when both land together
        d.of0 = set_of0 || (q.of0 && !timer0_flag_clear);
        d.of1 = set_of1 || (q.of1 && !timer1_flag_clear);

        // Read data held until the next read; unmapped reads zero
        if (sfr_rd) begin
            case (sfr_addr)
                ADDR_MODE_CONFIG: d.rdata = q.mode_cfg;
                ADDR_CLOCK_SELECT: d.rdata = q.clk_sel;
                ADDR_C0_LOW: d.rdata = q.c0_low;
                ADDR_C0_HIGH: d.rdata = q.c0_high;
                ADDR_C1_LOW: d.rdata = q.c1_low;
                ADDR_C1_HIGH: d.rdata = q.c1_high;
                default: d.rdata = REG_RESET;
            endcase
        end
    end

    // Run bits are never looked at here, so enabling keeps the count
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // Register-driven outputs
    assign sfr_rdata = q.rdata;
    assign timer0_overflow_flag = q.of0;
    assign timer1_overflow_flag = q.of1;
    assign timer1_overflow_pulse = q.c1_pulse;

    // Timer 2/3 byte clock enables; high select only counts when split
    assign timer2_low_tick = t23_tick(q.clk_sel[T2_LOW_BIT],
        timer2_ext_clock_select, tick12, tick_ext);
    assign timer2_high_tick = timer2_split ?
        t23_tick(q.clk_sel[T2_HIGH_BIT], timer2_ext_clock_select,
        tick12, tick_ext) : timer2_low_tick;
    assign timer3_low_tick = t23_tick(q.clk_sel[T3_LOW_BIT],
        timer3_ext_clock_select, tick12, tick_ext);
    assign timer3_high_tick = timer3_split ?
        t23_tick(q.clk_sel[T3_HIGH_BIT], timer3_ext_clock_select,
        tick12, tick_ext) : timer3_low_tick;

endmodule // timer01_mode_clock_select

// *** shared/timer01_pkg.sv ***
// Purpose: Shared constants and types for the Timer 0/1 block
// Assumes: 8-bit special-function-register bus, one 200 MHz clock
// Notes: Register offsets are the byte addresses on the register port
package timer01_pkg;

    // Register addresses
    localparam logic [7:0] ADDR_MODE_CONFIG = 8'h89;
    localparam logic [7:0] ADDR_C0_LOW = 8'h8a;
    localparam logic [7:0] ADDR_C1_LOW = 8'h8b;
    localparam logic [7:0] ADDR_C0_HIGH = 8'h8c;
    localparam logic [7:0] ADDR_C1_HIGH = 8'h8d;
    localparam logic [7:0] ADDR_CLOCK_SELECT = 8'h8e;
    localparam logic [7:0] REG_RESET = 8'h00;

    // Mode configuration fields
    localparam int GATEN1_BIT = 7;
    localparam int CT1_BIT = 6;
    localparam int T1MODE_LSB = 4;
    localparam int GATEN0_BIT = 3;
    localparam int CT0_BIT = 2;
    localparam int T0MODE_LSB = 0;

    // Clock select fields
    localparam int T3_HIGH_BIT = 7;
    localparam int T3_LOW_BIT = 6;
    localparam int T2_HIGH_BIT = 5;
    localparam int T2_LOW_BIT = 4;
    localparam int C1_SYSCLK_BIT = 3;
    localparam int C0_SYSCLK_BIT = 2;
    localparam int PRESCALE_LSB = 0;

    // Counter geometry
    localparam int LOW5_MSB = 4;

    // Divider ratios
    localparam int SYS_DIV_12 = 12;
    localparam int SYS_DIV_4 = 4;
    localparam int SYS_DIV_48 = 48;
    localparam int EXT_DIV_8 = 8;

    typedef enum logic [1:0] {
        MODE_13BIT = 2'b00,
        MODE_16BIT = 2'b01,
        MODE_8BIT_RELOAD = 2'b10,
        MODE_SPLIT = 2'b11
    } timer_mode_t;

    typedef enum logic [1:0] {
        PRESCALE_DIV12 = 2'b00,
        PRESCALE_DIV4 = 2'b01,
        PRESCALE_DIV48 = 2'b10,
        PRESCALE_EXT_DIV8 = 2'b11
    } prescale_sel_t;

endpackage

// *** logic/timer_prescaler.sv ***
// Purpose: System clock dividers and external clock divide-by-8 tick
// Assumes: External clock no faster than sys_clk
// Notes: Ticks are one-cycle enables on sys_clk
`timescale 1ns/10ps
module timer_prescaler #(
    parameter int DIV_A = timer01_pkg::SYS_DIV_12,
    parameter int DIV_B = timer01_pkg::SYS_DIV_4,
    parameter int DIV_C = timer01_pkg::SYS_DIV_48,
    parameter int DIV_X = timer01_pkg::EXT_DIV_8
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic ext_clk_in,
    output logic tick_div_a,
    output logic tick_div_b,
    output logic tick_div_c,
    output logic tick_ext
);
    import timer01_pkg::*;

    initial begin
        if (DIV_A < 2 || DIV_B < 2 || DIV_C < 2 || DIV_X < 2 ||
            DIV_A > 255 || DIV_B > 255 || DIV_C > 255 || DIV_X > 255) begin
            $error("timer_prescaler: ratios must be 2..255");
        end
    end

    typedef struct packed {
        logic [7:0] cnt_a;
        logic [7:0] cnt_b;
        logic [7:0] cnt_c;
        logic [7:0] cnt_x;
        logic sync1;
        logic sync2;
        logic sync3;
    } presc_state_t;

    presc_state_t q, d;

    // Free-running counters; external clock edges via two-flop sync
    always_comb begin
        d = q;
        d.cnt_a = (q.cnt_a == 8'(DIV_A - 1)) ? 8'h00 : q.cnt_a + 8'h01;
        d.cnt_b = (q.cnt_b == 8'(DIV_B - 1)) ? 8'h00 : q.cnt_b + 8'h01;
        d.cnt_c = (q.cnt_c == 8'(DIV_C - 1)) ? 8'h00 : q.cnt_c + 8'h01;
        d.sync1 = ext_clk_in;
        d.sync2 = q.sync1;
        d.sync3 = q.sync2;
        if (q.sync2 && !q.sync3) begin
            d.cnt_x = (q.cnt_x == 8'(DIV_X - 1)) ? 8'h00 :
                q.cnt_x + 8'h01;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // One tick per wrap of each counter
    assign tick_div_a = (q.cnt_a == 8'(DIV_A - 1));
    assign tick_div_b = (q.cnt_b == 8'(DIV_B - 1));
    assign tick_div_c = (q.cnt_c == 8'(DIV_C - 1));
    assign tick_ext = q.sync2 && !q.sync3 &&
        (q.cnt_x == 8'(DIV_X - 1));

endmodule // timer_prescaler

// *** logic/pin_fall_detect.sv ***
// Purpose: Falling-edge strobes for external count pins
// Assumes: Pins already synchronous to sys_clk
// Notes: One strobe per high-to-low transition
`timescale 1ns/10ps
module pin_fall_detect #(
    parameter int WIDTH = 2
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] fall
);
    initial begin
        if (WIDTH < 1) begin
            $error("pin_fall_detect: WIDTH must be at least 1");
        end
    end

    typedef struct packed {
        logic [WIDTH-1:0] last;
    } fall_state_t;

    fall_state_t q, d;

    // Previous level, sampled each cycle
    always_comb begin
        d = q;
        d.last = pin_in;
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // Strobe per bit, exactly one cycle per falling transition
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_fall
            assign fall[i] = q.last[i] && !pin_in[i];
        end
    endgenerate

endmodule // pin_fall_detect

// *** sim/timer01_sva.sv ***
// Purpose: Port-level checks for the Timer 0/1 block
// Assumes: Bound to timer01_mode_clock_select, one clock domain
// Notes: Mirrors the clock select byte to judge the tick outputs
`timescale 1ns/10ps
module timer01_sva (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic timer0_flag_clear,
    input wire logic timer0_overflow_flag,
    input wire logic timer2_ext_clock_select,
    input wire logic timer2_split,
    input wire logic timer3_split,
    input wire logic timer2_low_tick,
    input wire logic timer2_high_tick,
    input wire logic timer3_low_tick,
    input wire logic timer3_high_tick
);
    import timer01_pkg::*;
    logic [7:0] ck_q;
    logic mapped;
    logic t2_div;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    // Decode of the six mapped places
    assign mapped = sfr_addr inside {[8'h89:8'h8e]};
    assign t2_div = !ck_q[T2_LOW_BIT] && !timer2_ext_clock_select;
    // Shadow of the clock select byte
    always_ff @(posedge sys_clk) begin
        if (srst) ck_q <= 8'h00;
        else if (sfr_wr && sfr_addr == ADDR_CLOCK_SELECT) ck_q <= sfr_wdata;
    end
    AST_RD_RESET: assert property ($fell(srst) |-> sfr_rdata == 8'h00)
        else $error("read data not zero after reset");
    AST_RD_HOLD: assert property (!sfr_rd |=> $stable(sfr_rdata))
        else $error("read data moved without a read");
    AST_RD_UNMAPPED: assert property (sfr_rd && !mapped |=>
        sfr_rdata == 8'h00) else $error("unmapped read not zero");
    AST_RD_AFTER_WR: assert property (sfr_wr && mapped ##1
        sfr_rd && !sfr_wr && $stable(sfr_addr)
        |=> sfr_rdata == $past(sfr_wdata, 2))
        else $error("read after write lost the value");
    AST_T2_LOW_SYS: assert property (ck_q[T2_LOW_BIT] |-> timer2_low_tick)
        else $error("timer 2 low tick not system clock");
    AST_T3_LOW_SYS: assert property (ck_q[T3_LOW_BIT] |-> timer3_low_tick)
        else $error("timer 3 low tick not system clock");
    AST_T2_HIGH_SYS: assert property (timer2_split && ck_q[T2_HIGH_BIT]
        |-> timer2_high_tick) else $error("timer 2 high tick wrong");
    AST_T3_HIGH_FOLLOW: assert property (!timer3_split
        |-> timer3_high_tick == timer3_low_tick)
        else $error("timer 3 high tick differs outside split");
    AST_T2_DIV12_GAP: assert property (timer2_low_tick && t2_div
        |=> (!timer2_low_tick || !t2_div) [*8])
        else $error("divide by 12 tick too early");
    AST_T2_DIV12_NEXT: assert property (timer2_low_tick && t2_div
        |-> ##12 (timer2_low_tick || !t2_div))
        else $error("divide by 12 tick missing");
    AST_T0_FLAG_STICKY: assert property (timer0_overflow_flag
        && !timer0_flag_clear |=> timer0_overflow_flag)
        else $error("overflow flag dropped without clear");
endmodule // timer01_sva

bind timer01_mode_clock_select timer01_sva i_sva (
    .sys_clk(sys_clk), .srst(srst), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .timer0_flag_clear(timer0_flag_clear),
    .timer0_overflow_flag(timer0_overflow_flag),
    .timer2_ext_clock_select(timer2_ext_clock_select),
    .timer2_split(timer2_split), .timer3_split(timer3_split),
    .timer2_low_tick(timer2_low_tick), .timer2_high_tick(timer2_high_tick),
    .timer3_low_tick(timer3_low_tick), .timer3_high_tick(timer3_high_tick)
);

// *** sim/timer_pin_model.sv ***
// Purpose: Far-side pins: count pin falls and an external clock
// Assumes: Commanded by the bench on sys_clk
// Notes: Pins idle high; external clock stands still when off
`timescale 1ns/10ps
module timer_pin_model (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic go,
    input wire logic sel,
    input wire logic [7:0] burst,
    input wire logic ext_run,
    output logic [1:0] pins,
    output logic ext_clk
);
    logic [7:0] left;
    logic [1:0] ph;
    logic [2:0] ediv;
    // Each fall is high, low, low, high so no level is shorter than a cycle
    always_ff @(posedge sys_clk) begin
        if (srst || go) begin
            left <= srst ? 8'h00 : burst;
            ph <= 2'h0;
        end else if (left != 8'h00) begin
            ph <= ph + 2'h1;
            if (ph == 2'h3) left <= left - 8'h01;
        end
        pins <= 2'h3;
        if (left != 8'h00 && (ph == 2'h1 || ph == 2'h2)) pins[sel] <= 1'b0;
        // Period of six cycles keeps the source slower than sys_clk
        ediv <= (srst || ediv == 3'h5 || !ext_run) ? 3'h0 : ediv + 3'h1;
        ext_clk <= ext_run && ediv < 3'h3;
    end
endmodule // timer_pin_model

// *** sim/tb.sv ***
// Purpose: Self-checking bench for the Timer 0/1 block
// Assumes: Registers reached by strobes; pins from the pin model
// Notes: Random start values from a fixed seed, corners mixed in
`timescale 1ns/10ps
module tb;
    import timer01_pkg::*;
    logic sys_clk, srst, sfr_wr, sfr_rd, go, sel, ext_run, ext_clk;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, burst, d, hi, lo;
    logic [1:0] run, gate, pol, clr, flag, pins, x2s, spl, m;
    logic [3:0] tk;
    logic [7:0] ck_tab [4] = '{8'h00, 8'ha0, 8'h40, 8'h60};
    int div_tab [4] = '{12, 4, 48, 48}; // Last: model period 6 times 8
    int err_count, cmp_count, seed, t, n, c2, c3;
    timer01_mode_clock_select i_dut (
        .sys_clk(sys_clk), .srst(srst), .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
        .sfr_rdata(sfr_rdata), .timer0_run_bit(run[0]),
        .timer1_run_bit(run[1]), .ext_gate_input0(gate[0]),
        .ext_gate_input1(gate[1]), .ext_ext_gate_input0_polarity(pol[0]),
        .ext_ext_gate_input1_polarity(pol[1]), .timer0_count_pin(pins[0]),
        .timer1_count_pin(pins[1]), .ext_clk_in(ext_clk),
        .timer0_flag_clear(clr[0]), .timer1_flag_clear(clr[1]),
        .timer0_overflow_flag(flag[0]), .timer1_overflow_flag(flag[1]),
        .timer1_overflow_pulse(), .timer2_ext_clock_select(x2s[0]),
        .timer2_split(spl[0]), .timer3_ext_clock_select(x2s[1]),
        .timer3_split(spl[1]), .timer2_low_tick(tk[0]),
        .timer2_high_tick(tk[1]), .timer3_low_tick(tk[2]),
        .timer3_high_tick(tk[3])
    );
    timer_pin_model i_pins (
        .sys_clk(sys_clk), .srst(srst), .go(go), .sel(sel), .burst(burst),
        .ext_run(ext_run), .pins(pins), .ext_clk(ext_clk)
    );
    // Clock of 5 ns period
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    task conclude;
        $display("errors %0d compares %0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task check(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Register cycles; each leaves one idle edge so strobes never collide
    task wr(input logic [7:0] a, input logic [7:0] v);
        sfr_addr <= a;
        sfr_wdata <= v;
        sfr_wr <= 1'b1;
        @(posedge sys_clk);
        sfr_wr <= 1'b0;
        @(posedge sys_clk);
    endtask
    task rd(input logic [7:0] a);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge sys_clk);
        sfr_rd <= 1'b0;
        @(posedge sys_clk);
        d = sfr_rdata;
    endtask
    task wr_rd(input logic [7:0] a, input logic [7:0] v);
        sfr_addr <= a;
        sfr_wdata <= v;
        sfr_wr <= 1'b1;
        @(posedge sys_clk);
        sfr_wr <= 1'b0;
        sfr_rd <= 1'b1;
        @(posedge sys_clk);
        sfr_rd <= 1'b0;
        @(posedge sys_clk);
        d = sfr_rdata;
    endtask
    // One count of a timer: {flag, high, low}
    function logic [16:0] step(input logic [1:0] md, input logic [16:0] s);
        logic [7:0] h, l;
        logic o;
        {o, h, l} = s;
        case (md)
            2'h0: begin
                l[4:0] = l[4:0] + 5'h01;
                if (l[4:0] == 5'h00) h = h + 8'h01;
                if (l[4:0] == 5'h00 && h == 8'h00) o = 1'b1;
            end
            2'h1: begin
                {h, l} = {h, l} + 16'h0001;
                if ({h, l} == 16'h0000) o = 1'b1;
            end
            default: begin
                l = l + 8'h01;
                if (l == 8'h00) o = 1'b1;
                if (l == 8'h00 && md == 2'h2) l = h;
            end
        endcase
        return {o, h, l};
    endfunction
    // Load, run for nc cycles, then compare count bytes and flag
    task run_t(input int tt, input logic [1:0] md, input logic [7:0] vh,
            input logic [7:0] vl, input int nc, input int steps);
        logic [16:0] s;
        logic [7:0] al, ah;
        al = (md == 2'h3) ? ADDR_C0_HIGH : (tt ? ADDR_C1_LOW : ADDR_C0_LOW);
        ah = (md == 2'h3) ? ADDR_C0_LOW : (tt ? ADDR_C1_HIGH : ADDR_C0_HIGH);
        s = {1'b0, vh, vl};
        wr(al, vl);
        wr(ah, vh);
        clr[tt] <= 1'b1;
        @(posedge sys_clk);
        clr[tt] <= 1'b0;
        run[tt] <= 1'b1;
        go <= 1'b1;
        @(posedge sys_clk);
        go <= 1'b0;
        repeat (nc - 1) @(posedge sys_clk);
        run[tt] <= 1'b0;
        repeat (steps) s = step(md, s);
        rd(al);
        check(d, s[7:0]);
        rd(ah);
        check(d, s[15:8]);
        check({7'h00, flag[tt]}, {7'h00, s[16]});
    endtask
    // Hang guard
    initial begin
        #100000;
        err_count++;
        conclude();
    end
    // Main sequence
    initial begin
        seed = 87219;
        {srst, sfr_wr, sfr_rd, go, sel, ext_run} = 6'b100001;
        {sfr_addr, sfr_wdata, burst} = 24'h000000;
        {run, gate, pol, clr, x2s, spl} = 12'h030;
        repeat (4) @(posedge sys_clk);
        srst <= 1'b0;
        for (int a = 8'h88; a <= 8'h8f; a++) begin
            rd(8'(a));
            check(d, REG_RESET);
        end
        wr_rd(ADDR_MODE_CONFIG, 8'h5a);
        check(d, 8'h5a);
        wr_rd(ADDR_CLOCK_SELECT, 8'ha5);
        check(d, 8'ha5);
        wr_rd(8'h8f, 8'hff);
        check(d, 8'h00);
        wr(ADDR_CLOCK_SELECT, 8'h0c);
        for (int i = 0; i < 16; i++) begin
            t = i % 2;
            m = 2'($unsigned($random(seed)) % 3);
            hi = 8'($random(seed));
            lo = 8'($random(seed));
            n = 1 + $unsigned($random(seed)) % 40;
            if (i < 3) begin
                m = 2'(i);
                {hi, lo} = 16'hfffe;
                n = 20;
            end
            wr(ADDR_MODE_CONFIG, 8'(m) << (4 * t));
            run_t(t, m, hi, lo, n, n);
        end
        wr(ADDR_MODE_CONFIG, 8'h99);
        for (int k = 0; k < 8; k++) begin
            pol <= {2{k[1]}};
            gate <= {2{k[2]}};
            run_t(k % 2, 2'h1, 8'h00, 8'h40, 10, (k[1] == k[2]) ? 10 : 0);
        end
        wr(ADDR_MODE_CONFIG, 8'h30);
        run_t(1, 2'h1, 8'h00, 8'h00, 10, 0);
        burst <= 8'd5;
        for (int k = 0; k < 2; k++) begin
            sel <= k[0];
            wr(ADDR_MODE_CONFIG, k ? 8'h50 : 8'h05);
            run_t(k, 2'h1, 8'h12, 8'h34, 40, 5);
        end
        burst <= 8'd0;
        wr(ADDR_MODE_CONFIG, 8'h01);
        for (int p = 0; p < 4; p++) begin
            wr(ADDR_CLOCK_SELECT, 8'(p));
            n = (p == 3) ? 480 : 96;
            run_t(0, 2'h1, 8'h00, 8'h00, n, n / div_tab[p]);
        end
        wr(ADDR_MODE_CONFIG, 8'h33);
        wr(ADDR_CLOCK_SELECT, 8'h0c);
        run_t(1, 2'h3, 8'h00, 8'hfd, 5, 5);
        for (int j = 0; j < 4; j++) begin
            spl <= {2{j[0]}};
            x2s <= {2{j[1]}};
            wr(ADDR_CLOCK_SELECT, ck_tab[j]);
            c2 = 0;
            c3 = 0;
            repeat (96) begin
                @(posedge sys_clk);
                c2 += tk[0];
                c3 += tk[3];
            end
            check(8'(c2), ck_tab[j][4] ? 8'd96 : (j[1] ? 8'd2 : 8'd8));
            n = (j[0] ? ck_tab[j][7] : ck_tab[j][6]) ? 96 : (j[1] ? 2 : 8);
            check(8'(c3), 8'(n));
        end
        conclude();
    end
endmodule // tb
